// >>> src/char_sync_pkg.sv
// Shared types and constants for the character sync receiver.
// Assumes a core clock far faster than the sampled line clock.
package char_sync_pkg;

    // ----------------------------------------------------------------
    // Framing modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        MODE_SYNC = 3'h0,
        MODE_MONO = 3'h1,
        MODE_ASYN1 = 3'h2,
        MODE_ASYN15 = 3'h3,
        MODE_ASYN2 = 3'h4
    } mode_type;

    // ----------------------------------------------------------------
    // Bit-rate selections
    // ----------------------------------------------------------------
    typedef enum logic [3:0]
    {
        RATE_LOW = 4'h0,
        RATE_16K = 4'h1,
        RATE_19K2 = 4'h2,
        RATE_48K = 4'h3,
        RATE_64K = 4'h4
    } rate_type;

    // ----------------------------------------------------------------
    // Receiver configuration, characters held in normal order and sense
    // ----------------------------------------------------------------
    localparam int CHAR_MAX = 9;
    localparam int STOP_COUNT = 4;
    localparam int ITB_INDEX = 3;
    localparam int SIX_BIT_LEN = 4'h6;
    localparam logic [8:0] IDLE_CHAR = 9'h1FF;
    localparam logic [3:0] RESET_CHAR_LEN = 4'h8;

    typedef struct packed {
        mode_type mode;
        rate_type rate;
        logic [3:0] char_len;
        logic msb_first;
        logic inverted;
        logic sync_on_idles;
        logic [8:0] sync_char;
        logic [8:0] start_char;
        logic [STOP_COUNT-1:0][8:0] stop_char;
        logic [STOP_COUNT-1:0] stop_enable;
        logic check_enable;
        logic [8:0] transparent_char;
        logic transparent_enable;
        logic [8:0] drop_char;
        logic drop_enable;
        logic never_drop;
        logic clock_from_dce;
    } config_type;

    // ----------------------------------------------------------------
    // Received character word
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [8:0] value;
        logic in_check;
        logic end_block;
        logic itb;
    } char_word_type;

endpackage

// >>> src/char_skid_buffer.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes source and sink share CORE_CLK.
`timescale 1ns/10ps
module char_skid_buffer
#(
    parameter int WIDTH = 12
)
(
    input wire logic clk, // Core clock
    input wire logic reset_n, // Async reset, active low
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Offered word
    output logic out_valid, // Word held
    input wire logic out_ready, // Sink takes word
    output logic [WIDTH-1:0] out_data // Held word
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;
        logic [1:0] count;
    } state_type;

    state_type state;
    state_type next_state;

    // ----------------------------------------------------------------
    // Shift on pop, append on push
    // ----------------------------------------------------------------
    always_comb
    begin
        logic push;
        logic pop;
        next_state = state;
        push = in_valid && (state.count != 2'h2);
        pop = out_ready && (state.count != 2'h0);
        if (pop)
        begin
            next_state.slot[0] = state.slot[1];
        end
        if (push)
        begin
            if (pop)
                next_state.slot[state.count - 2'h1] = in_data;
            else
                next_state.slot[state.count[0]] = in_data;
        end
        next_state.count = state.count + {1'b0, push} - {1'b0, pop};
    end

    // Register the whole state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state <= '0;
        else
            state <= next_state;
    end

    assign in_ready = (state.count != 2'h2);
    assign out_valid = (state.count != 2'h0);
    assign out_data = state.slot[0];

endmodule

// >>> src/char_protocol_sync_receiver.sv
// Character-oriented serial line receiver: hunt, frame, bound check span.
// Assumes configuration ports are held steady while the line is watched.
//
// Summary of operation
// - Default LSB first, data not inverted
// - Bit order and sense applied to line
// - Stored characters converted before any compare
// - Check span after start, includes stop
// - Fourth stop character marks intermediate block
// - First three stops drop sync; ITB not
// - Six-bit code: stop bit 6 flips ITB status
// - Transparent character makes stop and start plain data; drop still acts
// - Sync, monosync, async with stop choices
// - Async checks only one stop bit
// - Two syncs, or one in monosync
// - Drop sync stops storing, resumes hunt
// - Bit clock from DTE or DCE side
// - Sync settings ignored in async modes
// - Async refuses 16K and 48K rates
// - Reset comes up in synchronous mode
// - Configured parity bit compared exactly
// - Sync on idles uses all-ones character
// - Never-drop setting keeps sync, stores idles
`timescale 1ns/10ps
module char_protocol_sync_receiver
(
    input wire logic CORE_CLK, // Core clock, 250 MHz
    input wire logic RESET_N, // Async reset, active low
    input wire logic LINE_DATA, // Monitored data line
    input wire logic DTE_CLOCK, // Line clock from DTE side
    input wire logic DCE_CLOCK, // Line clock from DCE side
    input wire char_sync_pkg::config_type CONFIG, // Receiver settings
    input wire logic CONFIG_LOAD, // Reset to defaults when high
    output char_sync_pkg::char_word_type CHAR_DATA, // Received char
    output logic CHAR_VALID, // Char available
    input wire logic CHAR_READY, // Sink takes char
    output logic IN_SYNC, // Framing achieved
    output logic RATE_REFUSED, // Bad rate for async
    output logic STOP_ERROR // Async stop bit low
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        HUNT = 2'h0,
        SECOND = 2'h1,
        FRAMED = 2'h2,
        ASYNC = 2'h3
    } phase_type;

    typedef struct packed {
        logic [1:0] data_sync;
        logic [1:0] dte_sync;
        logic [1:0] dce_sync;
        logic last_clock;
        phase_type phase;
        logic [8:0] shift;
        logic [3:0] bit_count;
        logic in_check;
        logic transparent;
        logic drop_pending;
        logic async_busy;
        logic word_valid;
        char_sync_pkg::char_word_type word;
        char_sync_pkg::config_type cfg;
        logic in_sync;
        logic rate_refused;
        logic stop_error;
    } state_type;

    state_type state;
    state_type next_state;
    logic buffer_ready;
    logic buffer_valid;
    char_sync_pkg::char_word_type buffer_data;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Map a normal-order character to what the shifter holds
    function automatic logic [8:0] to_line(input logic [8:0] value,
        input logic [3:0] len, input logic msb_first, input logic inv);
        logic [8:0] out;
        out = '0;
        for (int i = 0; i < char_sync_pkg::CHAR_MAX; i++)
        begin
            if (i < int'(len))
                out[i] = msb_first ? value[int'(len) - 1 - i] : value[i];
        end
        if (inv)
            out = out ^ ((9'h001 << len) - 9'h001);
        return out;
    endfunction

    // Mask to the configured character length
    function automatic logic [8:0] len_mask(input logic [3:0] len);
        return (9'h001 << len) - 9'h001;
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        logic clock_now;
        logic rise;
        logic bit_in;
        logic [8:0] mask;
        logic [8:0] window;
        logic [8:0] sync_line;
        logic sync_match;
        logic is_async;
        logic char_done;
        logic [8:0] value;
        logic is_stop;
        logic is_itb;
        logic drop_now;
        logic [3:0] len;
        clock_now = 1'b0;
        rise = 1'b0;
        bit_in = 1'b0;
        mask = '0;
        window = '0;
        sync_line = '0;
        sync_match = 1'b0;
        is_async = 1'b0;
        char_done = 1'b0;
        value = '0;
        is_stop = 1'b0;
        is_itb = 1'b0;
        drop_now = 1'b0;
        len = '0;
        next_state = state;

        // Two-flop synchronisers on the line data and both line clock pins
        next_state.data_sync = {state.data_sync[0], LINE_DATA};
        next_state.dte_sync = {state.dte_sync[0], DTE_CLOCK};
        next_state.dce_sync = {state.dce_sync[0], DCE_CLOCK};

        // Load settings; a load pulse restores defaults
        if (CONFIG_LOAD)
        begin
            next_state.cfg = '0;
            next_state.cfg.mode = char_sync_pkg::MODE_SYNC;
            next_state.cfg.char_len = char_sync_pkg::RESET_CHAR_LEN;
        end
        else
        begin
            next_state.cfg = CONFIG;
        end

        len = state.cfg.char_len;
        mask = len_mask(len);
        is_async = (state.cfg.mode != char_sync_pkg::MODE_SYNC) &&
            (state.cfg.mode != char_sync_pkg::MODE_MONO);
        // Async has no 16K or 48K, so such a setting idles the receiver
        next_state.rate_refused = is_async &&
            ((state.cfg.rate == char_sync_pkg::RATE_16K) ||
            (state.cfg.rate == char_sync_pkg::RATE_48K));

        // Clock source choice and edge find on the settled copy
        clock_now = state.cfg.clock_from_dce ? state.dce_sync[1] :
            state.dte_sync[1];
        next_state.last_clock = clock_now;
        rise = clock_now && !state.last_clock;
        bit_in = state.data_sync[1] ^ state.cfg.inverted;

        // Sync characters in line order, raw parity bit kept as set
        sync_line = state.cfg.sync_on_idles ? (char_sync_pkg::IDLE_CHAR &
            mask) : to_line(state.cfg.sync_char, len, state.cfg.msb_first,
            1'b0);

        if (state.word_valid && buffer_ready)
            next_state.word_valid = 1'b0;

        if (state.rate_refused)
        begin
            next_state.phase = char_sync_pkg::MODE_SYNC == state.cfg.mode
                ? HUNT : ASYNC;
            next_state.async_busy = 1'b0;
        end
        else if (is_async != (state.phase == ASYNC))
        begin
            // Change between async and sync framing reframes at once, no line clock needed
            next_state.phase = is_async ? ASYNC : HUNT;
            next_state.async_busy = 1'b0;
        end
        else if (rise)
        begin
            // New bit enters at the top so first bit ends lowest
            window = ({bit_in, state.shift[8:1]} >>
                (4'h9 - len)) & mask;
            next_state.shift = {bit_in, state.shift[8:1]};
            next_state.bit_count = state.bit_count + 4'h1;
            sync_match = (window == sync_line);
            unique case (state.phase)
                HUNT:
                begin
                    // Slide one bit per edge until a boundary is found
                    if (sync_match)
                    begin
                        next_state.bit_count = '0;
                        next_state.phase =
                            (state.cfg.mode == char_sync_pkg::MODE_MONO)
                            ? FRAMED : SECOND;
                    end
                end
                SECOND:
                begin
                    if (state.bit_count + 4'h1 == len)
                    begin
                        next_state.bit_count = '0;
                        next_state.phase = sync_match ? FRAMED : HUNT;
                    end
                end
                FRAMED:
                begin
                    if (state.bit_count + 4'h1 == len)
                    begin
                        next_state.bit_count = '0;
                        char_done = 1'b1;
                        value = window;
                    end
                end
                ASYNC:
                begin
                    // Start bit low, then len data bits, one stop bit
                    if (!state.async_busy)
                    begin
                        if (!state.data_sync[1])
                        begin
                            next_state.async_busy = 1'b1;
                            next_state.bit_count = '0;
                        end
                    end
                    else if (state.bit_count == len)
                    begin
                        // Only this stop bit is checked; extra ones idle
                        next_state.stop_error = !state.data_sync[1];
                        next_state.async_busy = 1'b0;
                        char_done = 1'b1;
                        value = (state.shift >> (4'h9 - len)) & mask;
                    end
                end
            endcase
        end

        // Character handling in framed or async modes
        if (char_done)
        begin
            for (int i = 0; i < char_sync_pkg::STOP_COUNT; i++)
            begin
                if (state.cfg.stop_enable[i] && (value == to_line(
                    state.cfg.stop_char[i], len, state.cfg.msb_first,
                    1'b0)))
                begin
                    is_stop = 1'b1;
                    // Fourth entry is the intermediate block end
                    is_itb = (i == char_sync_pkg::ITB_INDEX);
                    if ((len == char_sync_pkg::SIX_BIT_LEN[3:0]) &&
                        state.cfg.stop_char[i][len])
                        is_itb = !is_itb;
                end
            end
            // Transparent field turns stop and start characters into data; drop still acts
            if (!is_async && state.cfg.transparent_enable &&
                (value == to_line(state.cfg.transparent_char, len,
                state.cfg.msb_first, 1'b0)))
                next_state.transparent = !state.transparent;
            if (state.transparent && !is_async)
                is_stop = 1'b0;

            next_state.word.value = to_line(value, len,
                state.cfg.msb_first, 1'b0);
            next_state.word.in_check = state.in_check;
            next_state.word.end_block = 1'b0;
            next_state.word.itb = 1'b0;
            if (is_stop)
            begin
                // Stop keeps its span flag; any stop ends a block
                next_state.word.end_block = 1'b1;
                next_state.word.itb = is_itb;
                next_state.in_check = 1'b0;
                drop_now = !is_itb;
            end
            else if (state.cfg.check_enable && !state.transparent &&
                (value == to_line(state.cfg.start_char, len,
                state.cfg.msb_first, 1'b0)))
            begin
                // Start char itself is left out of the span
                next_state.in_check = 1'b1;
                next_state.word.in_check = 1'b0;
            end
            if (!is_async && state.cfg.drop_enable &&
                (value == to_line(state.cfg.drop_char, len,
                state.cfg.msb_first, 1'b0)))
                drop_now = 1'b1;
            if (is_async || state.cfg.never_drop)
                drop_now = 1'b0;
            next_state.word_valid = 1'b1;
            if (drop_now)
            begin
                // Hunt again and store nothing further
                next_state.phase = HUNT;
                next_state.in_check = 1'b0;
                next_state.transparent = 1'b0;
            end
        end

        next_state.in_sync = (next_state.phase == FRAMED) ||
            (next_state.phase == ASYNC);
    end

    // ----------------------------------------------------------------
    // State register; reset leaves synchronous mode, LSB, normal sense
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state <= '0;
            state.cfg.char_len <= char_sync_pkg::RESET_CHAR_LEN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Output buffer keeps words through sink stalls
    // ----------------------------------------------------------------
    char_skid_buffer
    #(
        .WIDTH($bits(char_sync_pkg::char_word_type))
    )
    buffer
    (
        .clk(CORE_CLK),
        .reset_n(RESET_N),
        .in_valid(state.word_valid),
        .in_ready(buffer_ready),
        .in_data(state.word),
        .out_valid(buffer_valid),
        .out_ready(CHAR_READY),
        .out_data(buffer_data)
    );

    assign CHAR_DATA = buffer_data;
    assign CHAR_VALID = buffer_valid;
    assign IN_SYNC = state.in_sync;
    assign RATE_REFUSED = state.rate_refused;
    assign STOP_ERROR = state.stop_error;

endmodule

// >>> testbench/char_sync_receiver_props.sv
// Checker for the character sync receiver, bound to its top module.
// Assumes one core clock domain and the package types at the ports.
`timescale 1ns/10ps
module char_sync_receiver_props
(
    input wire logic CORE_CLK, // Core clock
    input wire logic RESET_N, // Reset, active low
    input wire char_sync_pkg::config_type CONFIG, // Settings
    input wire logic CONFIG_LOAD, // Default load
    input wire char_sync_pkg::char_word_type CHAR_DATA, // Word held
    input wire logic CHAR_VALID, // Word available
    input wire logic CHAR_READY, // Sink takes word
    input wire logic IN_SYNC, // Framing held
    input wire logic RATE_REFUSED, // Bad async rate
    input wire logic STOP_ERROR // Stop bit low
);
    // ------------------------------------------------------------
    // Helper decode
    // ------------------------------------------------------------
    logic is_async;
    logic bad_rate;
    logic [3:0] since_sync;
    assign is_async = CONFIG.mode inside {char_sync_pkg::MODE_ASYN1,
        char_sync_pkg::MODE_ASYN15, char_sync_pkg::MODE_ASYN2};
    assign bad_rate = CONFIG.rate inside {char_sync_pkg::RATE_16K,
        char_sync_pkg::RATE_48K};
    // Cycles since framing held, saturating
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            since_sync <= 4'hF;
        else if (IN_SYNC)
            since_sync <= 4'h0;
        else if (since_sync != 4'hF)
            since_sync <= since_sync + 4'h1;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking dc @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    // Settings flop plus output flop
    sequence refuse_seq;
        (is_async && bad_rate && !CONFIG_LOAD) [*4];
    endsequence
    sequence async_ok;
        (is_async && !bad_rate && !CONFIG_LOAD) [*4];
    endsequence
    sequence sync_kept;
        (CONFIG.mode == char_sync_pkg::MODE_SYNC || CONFIG_LOAD) [*8];
    endsequence
    a_reset_quiet: assert property ($rose(RESET_N) |-> !CHAR_VALID
        && !IN_SYNC && !RATE_REFUSED && !STOP_ERROR)
        else $error("outputs busy just after reset");
    a_valid_holds: assert property (CHAR_VALID && !CHAR_READY
        |=> CHAR_VALID && $stable(CHAR_DATA))
        else $error("held word changed while stalled");
    a_rate_refused: assert property (refuse_seq |-> RATE_REFUSED)
        else $error("async rate not refused");
    a_rate_allowed: assert property
        ((!is_async || !bad_rate || CONFIG_LOAD) [*4] |-> !RATE_REFUSED)
        else $error("rate refused without cause");
    a_async_framed: assert property (async_ok |-> IN_SYNC)
        else $error("async mode not framed");
    a_hunt_wait: assert property
        ($rose(RESET_N) ##0 sync_kept |-> !IN_SYNC)
        else $error("framed without sync characters");
    a_store_synced: assert property
        ($rose(CHAR_VALID) |-> since_sync < 4'h8)
        else $error("word stored while hunting");
    a_refuse_quiet: assert property
        (RATE_REFUSED [*8] |-> !$rose(CHAR_VALID))
        else $error("word stored while rate refused");
endmodule

bind char_protocol_sync_receiver char_sync_receiver_props u_props
(
    .CORE_CLK(CORE_CLK),
    .RESET_N(RESET_N),
    .CONFIG(CONFIG),
    .CONFIG_LOAD(CONFIG_LOAD),
    .CHAR_DATA(CHAR_DATA),
    .CHAR_VALID(CHAR_VALID),
    .CHAR_READY(CHAR_READY),
    .IN_SYNC(IN_SYNC),
    .RATE_REFUSED(RATE_REFUSED),
    .STOP_ERROR(STOP_ERROR)
);

// >>> testbench/serial_line_source.sv
// Far-side model: a monitored serial line and its two line clocks.
// Assumes the caller sends one character at a time and waits for it.
`timescale 1ns/10ps
module serial_line_source
(
    input wire logic use_dce, // Clock from DCE side
    output logic line_data, // Serial data
    output logic dte_clock, // DTE line clock
    output logic dce_clock // DCE line clock
);
    // ------------------------------------------------------------
    // Idle: clocks stand still, line marks high
    // ------------------------------------------------------------
    initial
    begin
        line_data = 1'b1;
        dte_clock = 1'b0;
        dce_clock = 1'b0;
    end
    // Data set half a period before the rise
    task automatic send_char(input logic [8:0] v, input int len,
        input logic msb, input logic inv);
        for (int i = 0; i < len; i++)
        begin
            line_data = (msb ? v[len - 1 - i] : v[i]) ^ inv;
            #62.5;
            if (use_dce)
                dce_clock = 1'b1;
            else
                dte_clock = 1'b1;
            #62.5;
            dte_clock = 1'b0;
            dce_clock = 1'b0;
        end
        // Released line returns to its mark level
        line_data = 1'b1;
    endtask
endmodule

// >>> testbench/char_protocol_sync_receiver_tb.sv
// Bench for the character sync receiver: line source and word queue.
// Assumes package, buffer, receiver, checker built first.
`timescale 1ns/10ps
module char_protocol_sync_receiver_tb;
    logic CORE_CLK;
    logic RESET_N;
    logic CONFIG_LOAD;
    logic CHAR_READY;
    logic CHAR_VALID, IN_SYNC, RATE_REFUSED, STOP_ERROR;
    logic LINE_DATA, DTE_CLOCK, DCE_CLOCK;
    logic stall;
    logic bad;
    logic [15:0] lfsr;
    logic [11:0] exp_word[$];
    char_sync_pkg::config_type CONFIG;
    char_sync_pkg::char_word_type CHAR_DATA;
    int miscompares;
    int check_count;

    char_protocol_sync_receiver dut (.CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N), .LINE_DATA(LINE_DATA), .DTE_CLOCK(DTE_CLOCK),
        .DCE_CLOCK(DCE_CLOCK), .CONFIG(CONFIG), .CONFIG_LOAD(CONFIG_LOAD),
        .CHAR_DATA(CHAR_DATA), .CHAR_VALID(CHAR_VALID),
        .CHAR_READY(CHAR_READY), .IN_SYNC(IN_SYNC),
        .RATE_REFUSED(RATE_REFUSED), .STOP_ERROR(STOP_ERROR));
    serial_line_source u_line (.use_dce(CONFIG.clock_from_dce),
        .line_data(LINE_DATA), .dte_clock(DTE_CLOCK),
        .dce_clock(DCE_CLOCK));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        check_count++;
        if (seen !== want)
        begin
            miscompares++;
            $display("ERROR at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask
    // Queue owed word, then drive it on the line
    task automatic sendc(input logic [8:0] v, input logic keep,
        input logic [2:0] flags);
        if (keep)
            exp_word.push_back({v, flags});
        u_line.send_char(v, 8, CONFIG.msb_first, CONFIG.inverted);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, sink and word compare
    // ------------------------------------------------------------
    initial
    begin
        CORE_CLK = 1'b0;
        forever #2 CORE_CLK = ~CORE_CLK;
    end
    // Random sink stalls
    always @(posedge CORE_CLK)
    begin
        #1;
        lfsr = lfsr_next(lfsr);
        CHAR_READY = !stall && (lfsr[1:0] != 2'h0);
    end
    always @(posedge CORE_CLK)
    begin
        if (RESET_N && CHAR_VALID === 1'b1 && CHAR_READY === 1'b1)
        begin
            if (exp_word.size() == 0)
                check(12'h001, 12'h000);
            else
            begin
                check(CHAR_DATA, exp_word[0]);
                void'(exp_word.pop_front());
            end
        end
    end
    // Hang guard
    initial
    begin
        #200000;
        miscompares++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        RESET_N = 1'b0;
        CONFIG_LOAD = 1'b0;
        CHAR_READY = 1'b0;
        stall = 1'b0;
        lfsr = 16'h66CC; // 26316
        miscompares = 0;
        check_count = 0;
        CONFIG = '0;
        CONFIG.rate = char_sync_pkg::RATE_64K;
        CONFIG.char_len = 4'h8;
        CONFIG.sync_char = 9'h016;
        CONFIG.start_char = 9'h002;
        CONFIG.stop_char = {9'h017, 9'h005, 9'h004, 9'h003};
        CONFIG.stop_enable = 4'hF;
        CONFIG.check_enable = 1'b1;
        CONFIG.transparent_char = 9'h010;
        CONFIG.transparent_enable = 1'b1;
        repeat (2) @(posedge CORE_CLK);
        #1;
        RESET_N = 1'b1;
        wait_cyc(3);
        // Load beats a refused async setting
        CONFIG.mode = char_sync_pkg::MODE_ASYN1;
        CONFIG.rate = char_sync_pkg::RATE_16K;
        CONFIG_LOAD = 1'b1;
        wait_cyc(6);
        check({10'h0, IN_SYNC, RATE_REFUSED}, 12'h000);
        CONFIG_LOAD = 1'b0;
        for (int i = 0; i < 4; i++)
            for (int j = 0; j < 5; j++)
            begin
                CONFIG.mode = char_sync_pkg::mode_type'(3'(i ? i + 1 : 0));
                CONFIG.rate = char_sync_pkg::rate_type'(4'(j));
                wait_cyc(6);
                bad = (i > 0) && (j == 1 || j == 3);
                check({11'h0, RATE_REFUSED}, {11'h0, bad});
                if (i > 0 && !bad)
                    check({11'h0, IN_SYNC}, 12'h001);
            end
        CONFIG.mode = char_sync_pkg::MODE_SYNC;
        wait_cyc(6);
        check({11'h0, IN_SYNC}, 12'h000);
        // Sync mode, LSB first: odd bit offset, one then two syncs
        u_line.send_char(9'h007, 3, 1'b0, 1'b0);
        sendc(9'h016, 1'b0, 3'h0);
        wait_cyc(10);
        check({11'h0, IN_SYNC}, 12'h000);
        sendc(9'h016, 1'b0, 3'h0);
        wait_cyc(10);
        check({11'h0, IN_SYNC}, 12'h001);
        sendc(9'h041, 1'b1, 3'h0);
        sendc(9'h002, 1'b1, 3'h0);
        sendc(9'h055, 1'b1, 3'h4);
        sendc(9'h010, 1'b1, 3'h4);
        sendc(9'h003, 1'b1, 3'h4);
        sendc(9'h010, 1'b1, 3'h4);
        sendc(9'h017, 1'b1, 3'h7);
        wait_cyc(10);
        check({11'h0, IN_SYNC}, 12'h001);
        sendc(9'h003, 1'b1, 3'h2);
        wait_cyc(10);
        check({11'h0, IN_SYNC}, 12'h000);
        sendc(9'h044, 1'b0, 3'h0);
        // Monosync, MSB first, inverted, DCE clock
        CONFIG.mode = char_sync_pkg::MODE_MONO;
        CONFIG.msb_first = 1'b1;
        CONFIG.inverted = 1'b1;
        CONFIG.clock_from_dce = 1'b1;
        wait_cyc(6);
        u_line.send_char(9'h007, 3, 1'b0, 1'b0);
        sendc(9'h016, 1'b0, 3'h0);
        wait_cyc(10);
        check({11'h0, IN_SYNC}, 12'h001);
        // Sink stalls three words, then drains
        stall = 1'b1;
        for (int k = 0; k < 7; k++)
        begin
            if (k == 3)
                stall = 1'b0;
            sendc({4'h2, lfsr[4:0]}, 1'b1, 3'h0);
        end
        wait_cyc(200);
        check(12'(exp_word.size()), 12'h000);
        check({11'h0, STOP_ERROR}, 12'h000);
        tally_and_finish();
    end
endmodule
